// ==== hw/mmd_decoder.sv ====
// Memory map decoder: internal RAM, register banks, bit area, stack, xdata RAM
//
// Behaviour
// - 512-byte xdata RAM reached by MOVX via 16-bit pointer or 8-bit indirect.
// - 8-bit MOVX takes upper address byte from page-select register.
// - 16-bit MOVX ignores top seven bits; RAM repeats every 512 bytes.
// - Page-select bits 7..1 read zero and ignore writes.
// - Page-select bit 0 picks 256-byte page; 1 selects 0x0100..0x01FF.
// - MOVX goes to xdata RAM; writes go to flash only when write-enabled.
// - Flash program space is 0x0000..0x1DFF; higher addresses are reserved.
// - Bytes 0x1E00..0x1FFF stay reserved, unusable as program or data.
// - MOVX write reaches program memory when store-control bit 0 is set.
// - 256 bytes internal RAM; lower 128 reached directly and indirectly.
// - Above 0x7F, direct reaches SFRs and indirect reaches upper RAM.
// - Bytes 0x00..0x1F are four banks of eight registers, one active.
// - Registers 0 and 1 of active bank serve as indirect pointers.
// - Bit address below 0x80 maps to byte 0x20 plus high bits, bit position low bits.
// - Bit versus byte access chosen by instruction type only.
// - Push stores at pointer plus one, then increments pointer.
// - Stack pointer at 0x81 resets to 0x07, first push lands at 0x08.
// - Stack may lie anywhere in 256 bytes, depth up to 256.
// - Direct addresses 0x80..0xFF reach the special-function space.
module mmd_decoder
  import mmd_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Internal data access from the core
  input wire logic i_acc_valid,
  input wire mmd_acc_t i_acc_kind,
  input wire logic i_acc_write,
  input wire logic [7:0] i_acc_addr,
  input wire logic [2:0] i_acc_reg_sel,
  input wire logic i_acc_use_reg,
  input wire logic i_acc_ptr_sel,
  input wire logic [7:0] i_acc_wdata,
  // Xdata access from the core
  input wire logic i_movx_valid,
  input wire logic i_movx_wide,
  input wire logic i_movx_write,
  input wire logic [15:0] i_data_pointer_16,
  input wire logic [7:0] i_movx_wdata,
  // Program fetch address from the core
  input wire logic [15:0] i_prog_addr,
  // Internal data answer
  output logic [7:0] o_acc_rdata,
  output logic o_acc_bit,
  output logic o_acc_sfr_hit,
  // Xdata answer
  output logic [7:0] o_movx_rdata,
  output logic o_flash_wr,
  output logic [15:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  // Program fetch answer
  output logic o_prog_reserved,
  // Observed state
  output logic [7:0] o_stack_pointer,
  output logic [1:0] o_active_bank
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] stack_pointer_reg, stack_pointer_next;
  logic page_select_bit_reg;
  logic program_store_control_reg;
  logic [7:0] program_status_word_reg;
  logic [7:0] ptr_latch_reg;
  logic rd_bit_reg;
  logic [2:0] rd_bitpos_reg;
  logic rd_sfr_reg;
  logic [7:0] sfr_rdata_reg;
  logic flash_wr_reg;
  logic [15:0] flash_addr_reg;
  logic [7:0] flash_wdata_reg;

  // ****************************************
  // Internal address formation
  // ****************************************
  wire logic [1:0] active_bank = {program_status_word_reg[MMD_BANK_HI_BIT],
                                  program_status_word_reg[MMD_BANK_LO_BIT]};
  wire logic [7:0] bank_reg_addr = {3'h0, active_bank, i_acc_reg_sel};
  wire logic [7:0] direct_addr = i_acc_use_reg ? bank_reg_addr : i_acc_addr;
  wire logic [7:0] bit_byte_addr = i_acc_addr[7] ? {i_acc_addr[7:3], 3'h0}
                                   : MMD_BIT_AREA_BASE + {4'h0, i_acc_addr[6:3]};
  wire logic is_direct = (i_acc_kind == MMD_ACC_DIRECT);
  wire logic is_indirect = (i_acc_kind == MMD_ACC_INDIRECT);
  wire logic is_bit = (i_acc_kind == MMD_ACC_BIT);
  wire logic is_push = (i_acc_kind == MMD_ACC_PUSH);
  wire logic is_pop = (i_acc_kind == MMD_ACC_POP);
  wire logic [7:0] push_addr = stack_pointer_reg + 8'h01;
  // Direct or bit address at or above 0x80 targets the SFR space
  wire logic sfr_hit = i_acc_valid && (is_direct || is_bit)
                       && ((is_bit ? bit_byte_addr : direct_addr) >= MMD_UPPER_BASE);

  // Indirect pointer fetch: first cycle reads R0 or R1, result held in ptr_latch
  typedef enum logic [1:0] {MMD_ST_IDLE, MMD_ST_PTR, MMD_ST_USE} mmd_state_t;
  mmd_state_t state_reg, state_next;

  wire logic ind_start = i_acc_valid && is_indirect && (state_reg == MMD_ST_IDLE);
  wire logic [7:0] ptr_reg_addr = {3'h0, active_bank, 2'h0, i_acc_ptr_sel};

  // Internal RAM port selection
  logic [7:0] iram_addr;
  logic iram_we;
  logic [7:0] iram_wdata;
  wire logic [7:0] iram_rdata;
  wire logic [7:0] bit_mask = 8'h01 << i_acc_addr[2:0];

  always_comb
  begin
    iram_addr = direct_addr;
    iram_we = 1'b0;
    iram_wdata = i_acc_wdata;
    state_next = state_reg;
    case (state_reg)
      MMD_ST_IDLE:
      begin
        if (ind_start)
        begin
          iram_addr = ptr_reg_addr;
          state_next = MMD_ST_PTR;
        end
        else if (i_acc_valid && is_push)
        begin
          iram_addr = push_addr;
          iram_we = 1'b1;
        end
        else if (i_acc_valid && is_pop)
          iram_addr = stack_pointer_reg;
        else if (i_acc_valid && is_bit)
        begin
          iram_addr = bit_byte_addr;
          iram_we = i_acc_write && !sfr_hit;
          iram_wdata = i_acc_wdata[0] ? (bit_mask | 8'h00) : 8'h00;
        end
        else if (i_acc_valid && is_direct)
          iram_we = i_acc_write && !sfr_hit;
      end
      MMD_ST_PTR:
      begin
        state_next = MMD_ST_USE;
      end
      MMD_ST_USE:
      begin
        iram_addr = ptr_latch_reg; // full 256 bytes indirect
        iram_we = i_acc_write;
        state_next = MMD_ST_IDLE;
      end
      default:
        state_next = MMD_ST_IDLE;
    endcase
  end

  mmd_ram #(
    .AW(8),
    .DEPTH(MMD_IRAM_DEPTH)
  ) u_iram (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_we(iram_we),
    .i_addr(iram_addr),
    .i_wdata(iram_wdata),
    .o_rdata(iram_rdata)
  );

  // ****************************************
  // Xdata RAM and flash redirection
  // ****************************************
  wire logic [15:0] movx_addr = i_movx_wide ? i_data_pointer_16
                                : {7'h00, page_select_bit_reg, i_acc_wdata};
  wire logic [MMD_ON_CHIP_XDATA_RAM_AW-1:0] on_chip_xdata_ram_addr = movx_addr[MMD_ON_CHIP_XDATA_RAM_AW-1:0];
  wire logic to_flash = i_movx_valid && i_movx_write && program_store_control_reg;
  wire logic on_chip_xdata_ram_we = i_movx_valid && i_movx_write && !program_store_control_reg;
  // Flash writes outside ordinary storage are dropped
  wire logic flash_ok = (movx_addr <= MMD_FLASH_LAST);

  mmd_ram #(
    .AW(MMD_ON_CHIP_XDATA_RAM_AW),
    .DEPTH(MMD_ON_CHIP_XDATA_RAM_DEPTH)
  ) u_on_chip_xdata_ram (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_we(on_chip_xdata_ram_we),
    .i_addr(on_chip_xdata_ram_addr),
    .i_wdata(i_movx_wdata),
    .o_rdata(o_movx_rdata)
  );

  // ****************************************
  // SFR writes and reads
  // ****************************************
  wire logic sfr_wr = sfr_hit && is_direct && i_acc_write;
  wire logic sp_wr = sfr_wr && (direct_addr == MMD_SFR_STACK_POINTER);

  // Stack pointer next value
  always_comb
  begin
    stack_pointer_next = stack_pointer_reg;
    if (sp_wr)
      stack_pointer_next = i_acc_wdata;
    else if (state_reg == MMD_ST_IDLE && i_acc_valid && is_push)
      stack_pointer_next = push_addr;
    else if (state_reg == MMD_ST_IDLE && i_acc_valid && is_pop)
      stack_pointer_next = stack_pointer_reg - 8'h01;
  end

  logic [7:0] sfr_rd_mux;
  always_comb
  begin
    case (direct_addr)
      MMD_SFR_STACK_POINTER: sfr_rd_mux = stack_pointer_reg;
      MMD_SFR_PAGE_SELECT: sfr_rd_mux = {7'h00, page_select_bit_reg};
      MMD_SFR_PROG_STORE_CTL: sfr_rd_mux = {7'h00, program_store_control_reg};
      MMD_SFR_STATUS_WORD: sfr_rd_mux = program_status_word_reg;
      default: sfr_rd_mux = 8'h00;
    endcase
  end

  // Control registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      stack_pointer_reg <= MMD_SP_RESET;
      page_select_bit_reg <= MMD_PAGE_RESET[0];
      program_store_control_reg <= MMD_PSC_RESET[0];
      program_status_word_reg <= MMD_PSW_RESET;
    end
    else
    begin
      stack_pointer_reg <= stack_pointer_next;
      if (sfr_wr && direct_addr == MMD_SFR_PAGE_SELECT)
        page_select_bit_reg <= i_acc_wdata[MMD_PAGE_BIT];
      if (sfr_wr && direct_addr == MMD_SFR_PROG_STORE_CTL)
        program_store_control_reg <= i_acc_wdata[MMD_PSWE_BIT];
      if (sfr_wr && direct_addr == MMD_SFR_STATUS_WORD)
        program_status_word_reg <= i_acc_wdata;
    end
  end

  // Access pipeline state
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= MMD_ST_IDLE;
      rd_bit_reg <= 1'b0;
      rd_bitpos_reg <= 3'h0;
      rd_sfr_reg <= 1'b0;
      sfr_rdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      rd_bit_reg <= i_acc_valid && is_bit;
      rd_bitpos_reg <= i_acc_addr[2:0];
      rd_sfr_reg <= sfr_hit;
      sfr_rdata_reg <= sfr_rd_mux;
    end
  end

  // Pointer latch takes R0 or R1 value when the fetch completes
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      ptr_latch_reg <= 8'h00;
    else if (state_reg == MMD_ST_PTR)
      ptr_latch_reg <= iram_rdata;
  end

  // Flash write strobe, one cycle
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      flash_wr_reg <= 1'b0;
      flash_addr_reg <= 16'h0000;
      flash_wdata_reg <= 8'h00;
    end
    else
    begin
      flash_wr_reg <= to_flash && flash_ok;
      flash_addr_reg <= movx_addr;
      flash_wdata_reg <= i_movx_wdata;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire logic [7:0] data_sel = rd_sfr_reg ? sfr_rdata_reg : iram_rdata;
  assign o_acc_rdata = rd_bit_reg ? {7'h00, data_sel[rd_bitpos_reg]} : data_sel;
  assign o_acc_bit = rd_bit_reg;
  assign o_acc_sfr_hit = sfr_hit;
  assign o_flash_wr = flash_wr_reg;
  assign o_flash_addr = flash_addr_reg;
  assign o_flash_wdata = flash_wdata_reg;
  assign o_prog_reserved = (i_prog_addr > MMD_FLASH_LAST);
  assign o_stack_pointer = stack_pointer_reg;
  assign o_active_bank = active_bank;

  // ****************************************
  // Checks
  // ****************************************
  property p_sp_reset;
    @(posedge i_core_clk) !i_rst_n |=> (stack_pointer_reg == 8'h07);
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("sp not 0x07 after reset");

  property p_push;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (state_reg == MMD_ST_IDLE && i_acc_valid && is_push && !sp_wr)
      |-> iram_we && iram_addr == stack_pointer_reg + 8'h01
          ##1 stack_pointer_reg == $past(stack_pointer_reg) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");

  property p_pop;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (state_reg == MMD_ST_IDLE && i_acc_valid && is_pop && !ind_start)
      |=> stack_pointer_reg == $past(stack_pointer_reg) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not decrement");

  property p_page_read;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      sfr_rd_mux[7:1] == 7'h00 || direct_addr != MMD_SFR_PAGE_SELECT;
  endproperty
  a_page_read: assert property (p_page_read) else $error("page upper bits not zero");

  property p_movx_alias;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_movx_valid && i_movx_wide |-> on_chip_xdata_ram_addr == i_data_pointer_16[8:0];
  endproperty
  a_movx_alias: assert property (p_movx_alias) else $error("on_chip_xdata_ram alias wrong");

  property p_movx_page;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_movx_valid && !i_movx_wide |-> on_chip_xdata_ram_addr[8] == page_select_bit_reg;
  endproperty
  a_movx_page: assert property (p_movx_page) else $error("page bit not used");

  property p_flash_route;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_movx_valid && i_movx_write |-> (on_chip_xdata_ram_we != program_store_control_reg)
      ##1 (o_flash_wr == ($past(program_store_control_reg) && $past(flash_ok)));
  endproperty
  a_flash_route: assert property (p_flash_route) else $error("movx write misrouted");

  property p_bank;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_active_bank == {program_status_word_reg[4], program_status_word_reg[3]};
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");

  property p_sfr_direct;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && is_direct && direct_addr[7] |-> sfr_hit && !iram_we;
  endproperty
  a_sfr_direct: assert property (p_sfr_direct) else $error("direct high not sfr");

  c_push: cover property (@(posedge i_core_clk) i_acc_valid && is_push);
  c_indirect: cover property (@(posedge i_core_clk) state_reg == MMD_ST_USE);
  c_flash: cover property (@(posedge i_core_clk) o_flash_wr);
  c_bit: cover property (@(posedge i_core_clk) i_acc_valid && is_bit && i_acc_write);

endmodule : mmd_decoder

// ==== hw/mmd_pkg.sv ====
// Package: constants for the memory map decoder
package mmd_pkg;

  // ****************************************
  // Register addresses (special function space)
  // ****************************************
  localparam logic [7:0] MMD_SFR_STACK_POINTER = 8'h81;
  localparam logic [7:0] MMD_SFR_PAGE_SELECT = 8'haa;
  localparam logic [7:0] MMD_SFR_PROG_STORE_CTL = 8'h8f;
  localparam logic [7:0] MMD_SFR_STATUS_WORD = 8'hd0;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] MMD_SP_RESET = 8'h07;
  localparam logic [7:0] MMD_PAGE_RESET = 8'h00;
  localparam logic [7:0] MMD_PSC_RESET = 8'h00;
  localparam logic [7:0] MMD_PSW_RESET = 8'h00;
  localparam int MMD_PAGE_BIT = 0;
  localparam int MMD_PSWE_BIT = 0;
  localparam int MMD_BANK_LO_BIT = 3;
  localparam int MMD_BANK_HI_BIT = 4;

  // ****************************************
  // Address spaces
  // ****************************************
  localparam logic [7:0] MMD_UPPER_BASE = 8'h80;
  localparam logic [7:0] MMD_BIT_AREA_BASE = 8'h20;
  localparam logic [15:0] MMD_FLASH_LAST = 16'h1dff;
  localparam logic [15:0] MMD_RSVD_FIRST = 16'h1e00;
  localparam logic [15:0] MMD_RSVD_LAST = 16'h1fff;
  localparam int MMD_ON_CHIP_XDATA_RAM_AW = 9;
  localparam int MMD_ON_CHIP_XDATA_RAM_DEPTH = 512;
  localparam int MMD_IRAM_DEPTH = 256;

  // Access kinds issued by the core
  typedef enum logic [2:0] {
    MMD_ACC_DIRECT,
    MMD_ACC_INDIRECT,
    MMD_ACC_BIT,
    MMD_ACC_PUSH,
    MMD_ACC_POP,
    MMD_ACC_MOVX16,
    MMD_ACC_MOVX8,
    MMD_ACC_NONE
  } mmd_acc_t;

endpackage : mmd_pkg

// ==== hw/mmd_ram.sv ====
// Single-port byte RAM of flip-flops, with synchronous write and registered read
module mmd_ram
  import mmd_pkg::*;
#(
  parameter int AW = 8,
  parameter int DEPTH = 256
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Access port
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem_reg [DEPTH];
  logic [7:0] rdata_reg;

  // ****************************************
  // Storage, one flop row per entry
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_row
      always_ff @(posedge i_core_clk)
      begin
        if (!i_rst_n)
          mem_reg[gi] <= 8'h00;
        else if (i_we && (i_addr == AW'(gi)))
          mem_reg[gi] <= i_wdata;
      end
    end
  endgenerate

  // Registered read data
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= mem_reg[i_addr];
  end

  assign o_rdata = rdata_reg;

endmodule : mmd_ram

// ==== sim/mmd_core_model.sv ====
// Core model: issues internal and xdata accesses to the decoder
module mmd_core_model
  import mmd_pkg::*;
(
  // Clock and flash write answer {wr, addr, data}
  input wire logic i_core_clk,
  input wire logic [24:0] i_flash,
  // Internal access
  output logic o_acc_valid,
  output mmd_acc_t o_acc_kind,
  output logic o_acc_write,
  output logic [7:0] o_acc_addr,
  output logic [2:0] o_acc_reg_sel,
  output logic o_acc_use_reg,
  output logic o_acc_ptr_sel,
  output logic [7:0] o_acc_wdata,
  // Xdata access
  output logic o_movx_valid,
  output logic o_movx_wide,
  output logic o_movx_write,
  output logic [15:0] o_data_pointer_16,
  output logic [7:0] o_movx_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Idle levels and access tasks
  // ****************************************
  initial
  begin
    {o_acc_valid, o_acc_write, o_acc_use_reg, o_acc_ptr_sel} = 4'h0;
    {o_movx_valid, o_movx_wide, o_movx_write} = 3'h0;
    o_acc_kind = MMD_ACC_NONE;
    {o_acc_addr, o_acc_wdata, o_movx_wdata, o_acc_reg_sel} = 27'h0;
    o_data_pointer_16 = 16'h0000;
  end

  // Internal access; indirect is held three edges, then valid drops and address and data lines are inverted
  // Returns just after the taking edge, while the one-cycle answer stands
  task automatic acc(input mmd_acc_t kind, input logic wr, input logic [7:0] addr,
    input logic [7:0] wd, input logic use_reg, input logic [2:0] sel, input logic ptr);
    @(posedge i_core_clk);
    o_acc_valid <= 1'b1;
    o_acc_kind <= kind;
    o_acc_write <= wr;
    o_acc_addr <= addr;
    o_acc_wdata <= wd;
    o_acc_use_reg <= use_reg;
    o_acc_reg_sel <= sel;
    o_acc_ptr_sel <= ptr;
    repeat ((kind == MMD_ACC_INDIRECT) ? 3 : 1) @(posedge i_core_clk);
    o_acc_valid <= 1'b0;
    o_acc_kind <= MMD_ACC_NONE;
    o_acc_use_reg <= 1'b0;
    o_acc_addr <= ~addr;
    o_acc_wdata <= ~wd;
    #1;
  endtask : acc

  // Xdata access; low byte of an 8-bit address rides on the write-data lines
  task automatic movx(input logic wide, input logic wr, input logic [15:0] dp,
    input logic [7:0] wd, output logic [24:0] fl);
    @(posedge i_core_clk);
    o_movx_valid <= 1'b1;
    o_movx_wide <= wide;
    o_movx_write <= wr;
    o_data_pointer_16 <= dp;
    o_acc_wdata <= dp[7:0];
    o_movx_wdata <= wd;
    @(posedge i_core_clk);
    o_movx_valid <= 1'b0;
    o_data_pointer_16 <= ~dp;
    o_movx_wdata <= ~wd;
    #1;
    fl = i_flash;
  endtask : movx
endmodule : mmd_core_model

// ==== sim/mmd_decoder_test.sv ====
// Testbench: memory map decoder driven by the core model
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module mmd_decoder_test
  import mmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals, clock, instances
  // ****************************************
  logic i_core_clk, i_rst_n, acc_valid, acc_write, acc_use_reg, acc_ptr_sel;
  mmd_acc_t acc_kind;
  logic [7:0] acc_addr, acc_wdata, movx_wdata, acc_rdata, movx_rdata, flash_wdata;
  logic [7:0] stack_pointer;
  logic [2:0] acc_reg_sel;
  logic movx_valid, movx_wide, movx_write, acc_bit, acc_sfr_hit, flash_wr, prog_reserved;
  logic [15:0] dp16, prog_addr, flash_addr;
  logic [1:0] active_bank;
  logic [24:0] fl;
  logic sfr_seen;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  mmd_core_model core (.i_core_clk(i_core_clk), .i_flash({flash_wr, flash_addr, flash_wdata}),
    .o_acc_valid(acc_valid), .o_acc_kind(acc_kind), .o_acc_write(acc_write),
    .o_acc_addr(acc_addr), .o_acc_reg_sel(acc_reg_sel), .o_acc_use_reg(acc_use_reg),
    .o_acc_ptr_sel(acc_ptr_sel), .o_acc_wdata(acc_wdata), .o_movx_valid(movx_valid),
    .o_movx_wide(movx_wide), .o_movx_write(movx_write), .o_data_pointer_16(dp16),
    .o_movx_wdata(movx_wdata));

  mmd_decoder DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_acc_valid(acc_valid),
    .i_acc_kind(acc_kind), .i_acc_write(acc_write), .i_acc_addr(acc_addr),
    .i_acc_reg_sel(acc_reg_sel), .i_acc_use_reg(acc_use_reg), .i_acc_ptr_sel(acc_ptr_sel),
    .i_acc_wdata(acc_wdata), .i_movx_valid(movx_valid), .i_movx_wide(movx_wide),
    .i_movx_write(movx_write), .i_data_pointer_16(dp16), .i_movx_wdata(movx_wdata),
    .i_prog_addr(prog_addr), .o_acc_rdata(acc_rdata), .o_acc_bit(acc_bit),
    .o_acc_sfr_hit(acc_sfr_hit), .o_movx_rdata(movx_rdata), .o_flash_wr(flash_wr),
    .o_flash_addr(flash_addr), .o_flash_wdata(flash_wdata), .o_prog_reserved(prog_reserved),
    .o_stack_pointer(stack_pointer), .o_active_bank(active_bank));

  // Records the SFR-space flag of each taken request
  always @(posedge i_core_clk)
  begin
    if (acc_valid)
      sfr_seen <= acc_sfr_hit;
  end

  // Hang guard
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // ****************************************
  // Helpers and scenarios
  // ****************************************
  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    core.acc(MMD_ACC_DIRECT, 1'b1, a, d, 1'b0, 3'h0, 1'b0);
  endtask : dw

  task automatic dr(input logic [7:0] a);
    core.acc(MMD_ACC_DIRECT, 1'b0, a, 8'h00, 1'b0, 3'h0, 1'b0);
  endtask : dr

  task automatic ir(input logic ptr);
    core.acc(MMD_ACC_INDIRECT, 1'b0, 8'h00, 8'h00, 1'b0, 3'h0, ptr);
  endtask : ir

  task automatic t_reset();
    `CHK(stack_pointer, MMD_SP_RESET);
    dr(MMD_SFR_STACK_POINTER);
    `CHK(acc_rdata, 8'h07);
    dr(MMD_SFR_PAGE_SELECT);
    `CHK(acc_rdata, 8'h00);
    `CHK(active_bank, 2'h0);
  endtask : t_reset

  // Each bank selected in turn; its lands at bank * 8 + 7
  task automatic t_banks();
    for (int b = 0; b < 4; b++)
    begin
      dw(MMD_SFR_STATUS_WORD, 8'(b << 3));
      `CHK(active_bank, 2'(b));
      core.acc(MMD_ACC_DIRECT, 1'b1, 8'h00, 8'(8'h40 + b), 1'b1, 3'h7, 1'b0);
      dr(8'(b * 8 + 7));
      `CHK(acc_rdata, 8'(8'h40 + b));
    end
    dw(MMD_SFR_STATUS_WORD, 8'h00);
  endtask : t_banks

  // Upper RAM through R0, lower RAM through R1, versus SFR space through direct
  task automatic t_upper();
    dw(8'h00, 8'h90);
    dw(8'h01, 8'h45);
    core.acc(MMD_ACC_INDIRECT, 1'b1, 8'h00, 8'h5a, 1'b0, 3'h0, 1'b0);
    core.acc(MMD_ACC_INDIRECT, 1'b1, 8'h00, 8'h3c, 1'b0, 3'h0, 1'b1);
    dw(8'h90, 8'h77);
    ir(1'b0);
    `CHK(acc_rdata, 8'h5a);
    dr(8'h45);
    `CHK(acc_rdata, 8'h3c);
    `CHK(sfr_seen, 1'b0);
    dr(8'h90);
    `CHK(acc_rdata, 8'h00);
    `CHK(sfr_seen, 1'b1);
  endtask : t_upper

  task automatic t_bits();
    core.acc(MMD_ACC_BIT, 1'b1, 8'h13, 8'h01, 1'b0, 3'h0, 1'b0);
    core.acc(MMD_ACC_BIT, 1'b1, 8'h7f, 8'h01, 1'b0, 3'h0, 1'b0);
    dr(8'h22);
    `CHK(acc_rdata, 8'h08);
    `CHK(acc_bit, 1'b0);
    dr(8'h2f);
    `CHK(acc_rdata, 8'h80);
    core.acc(MMD_ACC_BIT, 1'b0, 8'h13, 8'h00, 1'b0, 3'h0, 1'b0);
    `CHK(acc_rdata[0], 1'b1);
    `CHK(acc_bit, 1'b1);
  endtask : t_bits

  task automatic t_stack();
    core.acc(MMD_ACC_PUSH, 1'b1, 8'h00, 8'ha1, 1'b0, 3'h0, 1'b0);
    `CHK(stack_pointer, 8'h08);
    core.acc(MMD_ACC_PUSH, 1'b1, 8'h00, 8'ha2, 1'b0, 3'h0, 1'b0);
    dr(8'h08);
    `CHK(acc_rdata, 8'ha1);
    dr(8'h09);
    `CHK(acc_rdata, 8'ha2);
    core.acc(MMD_ACC_POP, 1'b0, 8'h00, 8'h00, 1'b0, 3'h0, 1'b0);
    `CHK(acc_rdata, 8'ha2);
    `CHK(stack_pointer, 8'h08);
    dw(MMD_SFR_STACK_POINTER, 8'hfe);
    core.acc(MMD_ACC_PUSH, 1'b1, 8'h00, 8'h66, 1'b0, 3'h0, 1'b0);
    `CHK(stack_pointer, 8'hff);
    dw(8'h00, 8'hff);
    ir(1'b0);
    `CHK(acc_rdata, 8'h66);
  endtask : t_stack

  task automatic t_on_chip_xdata_ram();
    dw(MMD_SFR_PAGE_SELECT, 8'hff);
    dr(MMD_SFR_PAGE_SELECT);
    `CHK(acc_rdata, 8'h01);
    core.movx(1'b0, 1'b1, 16'h0034, 8'h77, fl);
    core.movx(1'b1, 1'b0, 16'hff34, 8'h00, fl);
    `CHK(movx_rdata, 8'h77);
    core.movx(1'b1, 1'b1, 16'h0010, 8'h55, fl);
    dw(MMD_SFR_PAGE_SELECT, 8'h00);
    core.movx(1'b0, 1'b0, 16'h0010, 8'h00, fl);
    `CHK(movx_rdata, 8'h55);
    core.movx(1'b1, 1'b0, 16'h0210, 8'h00, fl);
    `CHK(movx_rdata, 8'h55);
    core.movx(1'b1, 1'b0, 16'h0134, 8'h00, fl);
    `CHK(movx_rdata, 8'h77);
  endtask : t_on_chip_xdata_ram

  task automatic t_flash();
    dw(MMD_SFR_PROG_STORE_CTL, 8'h01);
    core.movx(1'b1, 1'b1, 16'h1234, 8'h9c, fl);
    `CHK(fl, {1'b1, 16'h1234, 8'h9c});
    core.movx(1'b1, 1'b1, 16'h1e00, 8'h9d, fl);
    `CHK(fl[24], 1'b0);
    dw(MMD_SFR_PROG_STORE_CTL, 8'h00);
    core.movx(1'b1, 1'b0, 16'h0034, 8'h00, fl);
    `CHK(movx_rdata, 8'h00);
    core.movx(1'b1, 1'b1, 16'h0034, 8'h11, fl);
    `CHK(fl[24], 1'b0);
    core.movx(1'b1, 1'b0, 16'h0034, 8'h00, fl);
    `CHK(movx_rdata, 8'h11);
  endtask : t_flash

  task automatic t_prog();
    logic [15:0] pa [5];
    pa = '{16'h0000, 16'h1dff, 16'h1e00, 16'h1fff, 16'hffff};
    foreach (pa[i])
    begin
      @(posedge i_core_clk);
      prog_addr <= pa[i];
      @(posedge i_core_clk);
      #1;
      `CHK(prog_reserved, 1'(pa[i] > MMD_FLASH_LAST));
    end
  endtask : t_prog

  // Main sequence
  initial
  begin
    i_rst_n = 1'b0;
    prog_addr = 16'h0000;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_banks();
    t_upper();
    t_bits();
    t_stack();
    t_on_chip_xdata_ram();
    t_flash();
    t_prog();
    end_of_test();
  end
endmodule : mmd_decoder_test
